// ---- logic/scr_top.v ----
// Switch command release and output sequencer top level.
`timescale 1ns/1ps
`include "scr_regs.vh"
module scr_top #(
	parameter TICK_CYC = `SCR_TICK_CYC
) (
	ref_clk,
	reset,
	cmd_req,
	cmd_close,
	cmd_remote,
	local_panel_source,
	bypass_req,
	password_ok,
	en_syslock,
	en_zone,
	mode_or,
	en_prot,
	en_double,
	en_oneofn,
	en_auth_local,
	en_auth_remote,
	en_nomact,
	unclr_mask,
	pulse_mode,
	out_time,
	seal_time,
	fb_time,
	end_time,
	sys_lock,
	rel_on_sel,
	rel_off_sel,
	prot_trip,
	other_busy,
	auth_remote,
	pos_closed,
	pos_open,
	feedback,
	out_close,
	out_open,
	busy,
	cmd_accept,
	cmd_reject,
	reject_code,
	fb_timeout,
	spont_fb
);
	input wire ref_clk;
	input wire reset;
	input wire cmd_req;
	input wire cmd_close;
	input wire cmd_remote;
	input wire local_panel_source;
	input wire bypass_req;
	input wire password_ok;
	input wire en_syslock;
	input wire en_zone;
	input wire mode_or;
	input wire en_prot;
	input wire en_double;
	input wire en_oneofn;
	input wire en_auth_local;
	input wire en_auth_remote;
	input wire en_nomact;
	input wire [6:0] unclr_mask;
	input wire pulse_mode;
	input wire [`SCR_TIME_W-1:0] out_time;
	input wire [`SCR_TIME_W-1:0] seal_time;
	input wire [`SCR_TIME_W-1:0] fb_time;
	input wire [`SCR_TIME_W-1:0] end_time;
	input wire sys_lock;
	input wire rel_on_sel;
	input wire rel_off_sel;
	input wire prot_trip;
	input wire other_busy;
	input wire auth_remote;
	input wire pos_closed;
	input wire pos_open;
	input wire feedback;
	output reg out_close;
	output reg out_open;
	output reg busy;
	output reg cmd_accept;
	output reg cmd_reject;
	output reg [`SCR_ERR_W-1:0] reject_code;
	output reg fb_timeout;
	output reg spont_fb;

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam ST_IDLE = 2'b00;
	localparam ST_WAIT = 2'b01;
	localparam ST_OUT = 2'b10;
	localparam ST_END = 2'b11;

	// Idle accepts a request at once. Wait holds an accepted command until
	// the next sampling tick. Out drives the contacts and watches feedback.
	// End keeps the command-end delay running and refuses new commands;
	// it is only entered in pulse mode with a nonzero delay.
	// The state is shared by both directions, so a command in one
	// direction always blocks a command in the other.

	reg [1:0] st_q;
	reg dir_q;
	reg last_valid_q;
	reg last_dir_q;
	reg [`SCR_TIME_W:0] out_cnt_q;
	reg [`SCR_TIME_W-1:0] fb_cnt_q;
	reg [`SCR_TIME_W-1:0] end_cnt_q;
	reg fb_seen_q;
	reg fb_live_q;
	reg sealed_q;
	reg fb_prev_q;
	wire tick;
	wire [`SCR_ERR_W-1:0] chk_err;
	wire same_last;
	wire at_target;

	// ----------------------------------------------------------------
	// Sampling tick and checks
	// ----------------------------------------------------------------
	scr_tick #(
		.TICK_CYC(TICK_CYC)
	) u_tick (
		.ref_clk(ref_clk),
		.reset(reset),
		.tick(tick)
	);

	assign same_last = last_valid_q & (last_dir_q == cmd_close);
	assign at_target = dir_q ? pos_closed : pos_open;

	// The check block reports one cause only. Its order is busy, end delay,
	// nominal equals actual, the lock pair, protection, double operation,
	// 1-of-N, local and remote authority. A bypass clears only the checks
	// whose unclearable bit is low; busy, end delay and the position check
	// are never bypassed because they protect the drive itself.
	// R11: bypass only after password
	scr_check u_check (
		.req_close(cmd_close),
		.req_remote(cmd_remote),
		.bypass(bypass_req & password_ok),
		.busy(st_q == ST_WAIT || st_q == ST_OUT),
		.en_syslock(en_syslock),
		.en_zone(en_zone),
		.mode_or(mode_or),
		.en_prot(en_prot),
		.en_double(en_double),
		.en_oneofn(en_oneofn),
		.en_auth_local(en_auth_local),
		.en_auth_remote(en_auth_remote),
		.en_nomact(en_nomact),
		.unclr_mask(unclr_mask),
		.sys_lock(sys_lock),
		.rel_on_sel(rel_on_sel),
		.rel_off_sel(rel_off_sel),
		.prot_trip(prot_trip),
		.same_as_last(same_last),
		.other_busy(other_busy),
		.auth_remote(auth_remote),
		.pos_closed(pos_closed),
		.pos_open(pos_open),
		.end_delay(st_q == ST_END),
		.err(chk_err)
	);

	// ----------------------------------------------------------------
	// Spontaneous feedback
	// ----------------------------------------------------------------
	// Only a rising feedback edge is reported. The contacts keep feedback
	// high until the drive is released, and a level test would flag that
	// ordinary tail as a spontaneous indication after every command.
	// Late feedback during a pulse that outlasts the window counts too.
	// R15: feedback after window is spontaneous
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			fb_prev_q <= 1'b0;
			spont_fb <= 1'b0;
		end
		else
		begin
			fb_prev_q <= feedback;
			spont_fb <= feedback & ~fb_prev_q & ~fb_live_q;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// A released command waits for the next tick before driving, so every
	// timed phase is its parameter plus up to one tick. Panel commands are not told
	// apart, since local_panel_source is unused, and see the same 0 to one tick margin.
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			st_q <= ST_IDLE;
			dir_q <= 1'b0;
			last_valid_q <= 1'b0;
			last_dir_q <= 1'b0;
			out_cnt_q <= {(`SCR_TIME_W+1){1'b0}};
			fb_cnt_q <= {`SCR_TIME_W{1'b0}};
			end_cnt_q <= {`SCR_TIME_W{1'b0}};
			fb_seen_q <= 1'b0;
			fb_live_q <= 1'b0;
			sealed_q <= 1'b0;
			out_close <= 1'b0;
			out_open <= 1'b0;
			busy <= 1'b0;
			cmd_accept <= 1'b0;
			cmd_reject <= 1'b0;
			reject_code <= `SCR_ERR_NONE;
			fb_timeout <= 1'b0;
		end
		else
		begin
			cmd_accept <= 1'b0;
			cmd_reject <= 1'b0;
			fb_timeout <= 1'b0;
			// A refused request leaves the sequencer untouched; only the
			// cause is kept so that it can still be read after the pulse.
			// R20: reject with cause
			if (cmd_req && chk_err != `SCR_ERR_NONE)
			begin
				cmd_reject <= 1'b1;
				reject_code <= chk_err;
			end
			case (st_q)
				ST_IDLE, ST_END:
				begin
					if (st_q == ST_END && tick)
					begin
						if (end_cnt_q <= 8'h01)
							st_q <= ST_IDLE;
						end_cnt_q <= end_cnt_q - 1'b1;
					end
					if (cmd_req && chk_err == `SCR_ERR_NONE)
					begin
						cmd_accept <= 1'b1;
						reject_code <= `SCR_ERR_NONE;
						dir_q <= cmd_close;
						last_valid_q <= 1'b1;
						last_dir_q <= cmd_close;
						busy <= 1'b1;
						st_q <= ST_WAIT;
					end
				end
				ST_WAIT:
				begin
					// R18: start on first tick
					// R19: panel waits only for the next tick, like any command
					if (tick)
					begin
						// R17: output mode
						out_close <= dir_q;
						out_open <= ~dir_q;
						out_cnt_q <= {1'b0, out_time};
						fb_cnt_q <= fb_time;
						fb_seen_q <= 1'b0;
						fb_live_q <= 1'b1;
						sealed_q <= 1'b0;
						st_q <= ST_OUT;
					end
				end
				ST_OUT:
				begin
					if (feedback)
						fb_seen_q <= 1'b1;
					if (tick)
					begin
						// The window counts whole ticks, so it closes at its
						// parameter plus the part of a tick before output began.
						if (fb_live_q && !fb_seen_q && !feedback)
						begin
							if (fb_cnt_q <= 8'h01)
							begin
								fb_live_q <= 1'b0;
								fb_timeout <= 1'b1;
							end
							fb_cnt_q <= fb_cnt_q - 1'b1;
						end
						if (pulse_mode)
						begin
							out_cnt_q <= out_cnt_q - 1'b1;
							if (out_cnt_q <= 9'h001)
							begin
								// Seal-in is granted once only, so a drive that never
								// reaches its end position cannot hold the output forever.
								// R14: seal-in extension
								if (fb_seen_q && !at_target && !sealed_q && seal_time != 8'h00)
								begin
									sealed_q <= 1'b1;
									out_cnt_q <= {1'b0, seal_time};
								end
								else
								begin
									out_close <= 1'b0;
									out_open <= 1'b0;
									busy <= 1'b0;
									fb_live_q <= 1'b0;
									end_cnt_q <= end_time;
									// R16: end delay start
									st_q <= (end_time != 8'h00) ? ST_END : ST_IDLE;
								end
							end
						end
						// A persistent output ends on the tick that sees both the
						// feedback and the end position, or after the window expired.
						else if ((fb_seen_q || feedback) && at_target)
						begin
							out_close <= 1'b0;
							out_open <= 1'b0;
							busy <= 1'b0;
							fb_live_q <= 1'b0;
							st_q <= ST_IDLE;
						end
						else if (!fb_live_q)
						begin
							out_close <= 1'b0;
							out_open <= 1'b0;
							busy <= 1'b0;
							st_q <= ST_IDLE;
						end
					end
				end
				default:
					st_q <= ST_IDLE;
			endcase
		end
	end
endmodule // scr_top

// ---- logic/scr_regs.vh ----
// Constants for the switch command release and output sequencer.
// Function
// R01: System lock reported withholds the command
// R02: AND mode: neither lock nor zone
// R03: OR mode: one condition alone tolerated
// R04: AND/OR apply only with both checks
// R05: Protection trip blocks close, never open
// R06: Refuse command identical to last output
// R07: 1-of-N: refuse while another device busy
// R08: Always refuse second command while busy
// R09: Local command needs authority Local
// R10: Remote command needs authority Remote
// R11: Bypass skips locks except unclearable ones
// R12: Refuse when target equals actual position
// R13: Per-direction release condition, None allowed
// R14: Pulse held duration, seal-in extension
// R15: Late feedback flagged as spontaneous
// R16: Command-end delay blocks re-output
// R17: Persistent or pulse output mode
// R18: 100 ms tick, time plus 0..99 ms
// R19: Local panel always gets full margin; local_panel_source is unused, panel commands wait only for the next tick
// R20: Refusal reports the refusing check
`ifndef SCR_REGS_VH
`define SCR_REGS_VH
`define SCR_CLK_HZ 125000000
`define SCR_TICK_MS 100
`define SCR_TICK_CYC ((`SCR_CLK_HZ / 1000) * `SCR_TICK_MS)
`define SCR_TICK_W 24
`define SCR_TIME_W 8
`define SCR_ERR_W 4
`define SCR_ERR_NONE 4'h0
`define SCR_ERR_BUSY 4'h1
`define SCR_ERR_SYSLOCK 4'h2
`define SCR_ERR_ZONE 4'h3
`define SCR_ERR_PROT 4'h4
`define SCR_ERR_DOUBLE 4'h5
`define SCR_ERR_ONEOFN 4'h6
`define SCR_ERR_AUTH_L 4'h7
`define SCR_ERR_AUTH_R 4'h8
`define SCR_ERR_NOMACT 4'h9
`define SCR_ERR_ENDDLY 4'hA
`endif

// ---- logic/scr_tick.v ----
// Sampling tick divider producing a one-cycle enable every 100 ms.
`timescale 1ns/1ps
`include "scr_regs.vh"
module scr_tick #(
	parameter TICK_CYC = `SCR_TICK_CYC
) (
	ref_clk,
	reset,
	tick
);
	input wire ref_clk;
	input wire reset;
	output reg tick;
	reg [`SCR_TICK_W-1:0] cnt_q;
	// R18: sampling tick
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			cnt_q <= {`SCR_TICK_W{1'b0}};
			tick <= 1'b0;
		end
		else if (cnt_q == TICK_CYC - 1)
		begin
			cnt_q <= {`SCR_TICK_W{1'b0}};
			tick <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule // scr_tick

// ---- logic/scr_check.v ----
// Combinational release checks for one command request.
`timescale 1ns/1ps
`include "scr_regs.vh"
module scr_check (
	req_close,
	req_remote,
	bypass,
	busy,
	en_syslock,
	en_zone,
	mode_or,
	en_prot,
	en_double,
	en_oneofn,
	en_auth_local,
	en_auth_remote,
	en_nomact,
	unclr_mask,
	sys_lock,
	rel_on_sel,
	rel_off_sel,
	prot_trip,
	same_as_last,
	other_busy,
	auth_remote,
	pos_closed,
	pos_open,
	end_delay,
	err
);
	input wire req_close;
	input wire req_remote;
	input wire bypass;
	input wire busy;
	input wire en_syslock;
	input wire en_zone;
	input wire mode_or;
	input wire en_prot;
	input wire en_double;
	input wire en_oneofn;
	input wire en_auth_local;
	input wire en_auth_remote;
	input wire en_nomact;
	input wire [6:0] unclr_mask;
	input wire sys_lock;
	input wire rel_on_sel;
	input wire rel_off_sel;
	input wire prot_trip;
	input wire same_as_last;
	input wire other_busy;
	input wire auth_remote;
	input wire pos_closed;
	input wire pos_open;
	input wire end_delay;
	output reg [`SCR_ERR_W-1:0] err;
	// Unclearable mask bits: 0 syslock, 1 zone, 2 prot, 3 double, 4 1-of-N, 5 local, 6 remote.
	reg [6:0] act;
	reg zone;
	reg lk;
	always @*
	begin
		act = bypass ? unclr_mask : 7'h7F;
		// R13: release condition per direction
		zone = en_zone & ~(req_close ? rel_on_sel : rel_off_sel) & act[1];
		lk = en_syslock & sys_lock & act[0];
		err = `SCR_ERR_NONE;
		// R08: busy always refused
		if (busy)
			err = `SCR_ERR_BUSY;
		// R16: command-end delay
		else if (end_delay)
			err = `SCR_ERR_ENDDLY;
		// R12: nominal equals actual
		else if (en_nomact & (req_close ? pos_closed : pos_open))
			err = `SCR_ERR_NOMACT;
		// R04: OR mode only with both checks on
		// R03: OR tolerates one condition
		// A bypassed condition counts as absent, so OR mode sees only the
		// conditions that remain in force.
		else if (en_zone & en_syslock & mode_or)
		begin
			if (lk & zone)
				err = `SCR_ERR_SYSLOCK;
		end
		// R01: system lock withholds
		// R02: AND mode needs neither
		else if (lk)
			err = `SCR_ERR_SYSLOCK;
		else if (zone)
			err = `SCR_ERR_ZONE;
		// R05: close blocked by trip
		if (err == `SCR_ERR_NONE)
		begin
			if (act[2] & en_prot & prot_trip & req_close)
				err = `SCR_ERR_PROT;
			// R06: duplicate command
			else if (act[3] & en_double & same_as_last)
				err = `SCR_ERR_DOUBLE;
			// R07: 1-of-N blocking
			else if (act[4] & en_oneofn & other_busy)
				err = `SCR_ERR_ONEOFN;
			// R09: local authority
			else if (act[5] & en_auth_local & ~req_remote & auth_remote)
				err = `SCR_ERR_AUTH_L;
			// R10: remote authority
			else if (act[6] & en_auth_remote & req_remote & ~auth_remote)
				err = `SCR_ERR_AUTH_R;
		end
	end
endmodule // scr_check

// ---- dv/scr_top_checker.sv ----
// Port assertions for the command release sequencer.
`timescale 1ns/1ps
`include "scr_regs.vh"
module scr_top_checker (
	input wire ref_clk,
	input wire reset,
	input wire cmd_req,
	input wire cmd_close,
	input wire cmd_remote,
	input wire bypass_req,
	input wire password_ok,
	input wire en_syslock,
	input wire en_zone,
	input wire mode_or,
	input wire en_prot,
	input wire en_auth_local,
	input wire en_nomact,
	input wire sys_lock,
	input wire prot_trip,
	input wire auth_remote,
	input wire pos_closed,
	input wire pos_open,
	input wire out_close,
	input wire out_open,
	input wire busy,
	input wire cmd_accept,
	input wire cmd_reject,
	input wire [`SCR_ERR_W-1:0] reject_code
);
	// ------
	// Checks
	// ------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	wire byp = bypass_req && password_ok;
	sequence s_refused;
		cmd_reject && !cmd_accept;
	endsequence
	a_single_answer: assert property (cmd_req |=> cmd_accept != cmd_reject)
		else $error("no single answer");
	a_busy_refused: assert property (cmd_req && busy |=>
		s_refused ##0 reject_code == `SCR_ERR_BUSY) else $error("busy not refused");
	a_lock_withheld: assert property (cmd_req && en_syslock && sys_lock && !byp &&
		!(mode_or && en_zone) |=> s_refused) else $error("lock ignored");
	a_close_blocked: assert property (cmd_req && cmd_close && en_prot && prot_trip &&
		!byp |=> s_refused) else $error("trip ignored");
	a_target_reached: assert property (cmd_req && en_nomact &&
		(cmd_close ? pos_closed : pos_open) |=> s_refused) else $error("at target");
	a_local_auth: assert property (cmd_req && en_auth_local && !cmd_remote &&
		auth_remote && !byp |=> s_refused) else $error("authority ignored");
	a_one_direction: assert property (!(out_close && out_open))
		else $error("both outputs");
	a_out_in_busy: assert property ((out_close || out_open) |-> busy)
		else $error("output while idle");
endmodule // scr_top_checker

bind scr_top scr_top_checker u_scr_top_checker (.*);

// ---- dv/scr_gear_model.sv ----
// Switchgear contact model answering the command outputs.
`timescale 1ns/1ps
module scr_gear_model (
	input wire ref_clk,
	input wire reset,
	input wire out_close,
	input wire out_open,
	input wire slow,
	input wire late,
	output logic feedback,
	output logic pos_closed,
	output logic pos_open
);
	int cnt;
	// ------
	// Travel
	// ------
	// A slow drive reports feedback long before it reaches its end position.
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			cnt <= 0;
			feedback <= 1'h0;
			{pos_closed, pos_open} <= 2'h1;
		end
		else if (out_close || out_open)
		begin
			cnt <= cnt + 1;
			if (cnt == 1)
				{pos_closed, pos_open} <= 2'h0;
			if (cnt == (late ? 30 : 4))
				feedback <= 1'h1;
			if (cnt == (slow ? 70 : 6))
				{pos_closed, pos_open} <= {out_close, out_open};
		end
		else
		begin
			cnt <= 0;
			feedback <= 1'h0;
		end
	end
endmodule // scr_gear_model

// ---- dv/switch_command_release_output_bench.sv ----
// Self-checking bench for the command release sequencer.
`timescale 1ns/1ps
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin bad_count++; \
	$display("wrong value at %0t: %h %h", $time, g, x); end end
module switch_command_release_output_bench;
	localparam int TK = 20;
	logic ref_clk, reset, cmd_req, cmd_close, cmd_remote, local_panel_source, slow;
	logic bypass_req, password_ok, en_syslock, en_zone, mode_or, en_prot, en_double;
	logic en_oneofn, en_auth_local, en_auth_remote, en_nomact, pulse_mode, sys_lock;
	logic rel_on_sel, rel_off_sel, prot_trip, other_busy, auth_remote, indly, late;
	logic [6:0] unclr_mask;
	logic [7:0] out_time, seal_time, fb_time, end_time;
	wire pos_closed, pos_open, feedback, out_close, out_open, busy, cmd_accept;
	wire cmd_reject, fb_timeout, spont_fb;
	wire [3:0] reject_code;
	int bad_count, check_count, cyc, e, hi, n, sp_n, to_n;
	int hist[$];
	scr_top #(.TICK_CYC(TK)) u_scr_top (.*);
	scr_gear_model u_scr_gear_model (.*);
	initial
	begin
		ref_clk = 1'h0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			bad_count++;
			give_verdict;
		end
	end
	always @(negedge ref_clk)
	begin
		sp_n += spont_fb;
		to_n += fb_timeout;
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task step(int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	// ------
	// Model
	// ------
	function automatic int exp_code(bit c);
		bit b, sl, zn;
		b = bypass_req & password_ok;
		sl = en_syslock & sys_lock & (!b | unclr_mask[0]);
		zn = en_zone & !(c ? rel_on_sel : rel_off_sel) & (!b | unclr_mask[1]);
		if (busy) return 1;
		if (indly) return 10;
		if (en_nomact && (c ? pos_closed : pos_open)) return 9;
		if (sl && (zn || !(mode_or && en_zone))) return 2;
		if (zn && !(mode_or && en_syslock)) return 3;
		if (c && en_prot && prot_trip && (!b | unclr_mask[2])) return 4;
		if (en_double && hist.size() > 0 && hist[$] == c && (!b | unclr_mask[3])) return 5;
		if (en_oneofn && other_busy && (!b | unclr_mask[4])) return 6;
		if (en_auth_local && !cmd_remote && auth_remote && (!b | unclr_mask[5])) return 7;
		if (en_auth_remote && cmd_remote && !auth_remote && (!b | unclr_mask[6])) return 8;
		return 0;
	endfunction
	task automatic issue(bit c, bit r);
		cmd_close = c;
		cmd_remote = r;
		e = exp_code(c);
		cmd_req = 1'h1;
		step(1);
		cmd_req = 1'h0;
		for (n = 0; cmd_accept !== 1'h1 && cmd_reject !== 1'h1 && n < 4; n++)
			step(1);
		`CHK(cmd_accept, e == 0)
		`CHK(reject_code, e[3:0])
		if (e == 0)
			hist.push_back(c);
	endtask
	task automatic drain(bit cool);
		hi = 0;
		for (n = 0; busy === 1'h1 && n < 3000; n++)
		begin
			hi += out_close | out_open;
			step(1);
		end
		`CHK(busy, 1'h0)
		if (pulse_mode)
			`CHK(hi / TK, out_time + (slow ? seal_time : 0))
		indly = pulse_mode & !cool;
		if (cool)
			step((end_time + 2) * TK);
	endtask
	initial
	begin
		{cmd_req, cmd_close, cmd_remote, local_panel_source, slow, bypass_req} = '0;
		{password_ok, en_syslock, en_zone, mode_or, en_prot, en_double, indly, late} = '0;
		{en_oneofn, en_auth_local, en_auth_remote, en_nomact, sys_lock} = '0;
		{prot_trip, other_busy, auth_remote, unclr_mask} = '0;
		{rel_on_sel, rel_off_sel, pulse_mode} = 3'h7;
		{out_time, seal_time, fb_time, end_time} = 32'h02010502;
		reset = 1'h1;
		void'($urandom(32'h9A97F20E));
		step(20);
		reset = 1'h0;
		issue(1'h1, 1'h0);
		issue(1'h0, 1'h0);
		drain(1'h0);
		issue(1'h0, 1'h0);
		indly = 1'h0;
		step((end_time + 2) * TK);
		$display("test busy and end delay done");
		slow = 1'h1;
		issue(1'h0, 1'h0);
		drain(1'h1);
		$display("test seal-in done");
		{slow, pulse_mode} = 2'h0;
		issue(1'h1, 1'h0);
		drain(1'h1);
		$display("test persistent done");
		{late, fb_time} = 9'h101;
		issue(1'h0, 1'h0);
		drain(1'h1);
		`CHK(to_n, 1)
		`CHK(sp_n, 1)
		{late, fb_time} = 9'h005;
		$display("test late feedback done");
		for (int i = 0; i < 60; i++)
		begin
			{en_syslock, en_zone, mode_or, en_prot, en_double, en_oneofn, en_auth_local,
				en_auth_remote, en_nomact, bypass_req, password_ok, pulse_mode,
				slow} = 13'($urandom);
			{sys_lock, prot_trip, other_busy} = 3'($urandom & $urandom);
			{rel_on_sel, rel_off_sel, auth_remote, local_panel_source} = 4'($urandom);
			unclr_mask = 7'($urandom);
			issue(1'($urandom), 1'($urandom));
			if (e == 0)
				drain(1'h1);
		end
		`CHK(sp_n + to_n, 2)
		$display("test random checks done");
		give_verdict;
	end
endmodule // switch_command_release_output_bench
